// file: common/scan_regs_pkg.sv
// constants for the gpio and scan sequencer register bank
// assumes one 100 MHz clock and an i2c host on synchronous pin samples
// Notes on behaviour
// RULE1 - each drive-style bit makes its output open-drain when clear and push-pull when set.
// RULE2 - bit n of the output-level register drives digital output n to that logic level.
// RULE3 - the read-only input-level register returns the sampled level of each digital input.
// RULE4 - a set scan-run bit in automatic mode scans enabled channels upward from the lowest.
// RULE5 - writing the scan-run bit to zero stops the automatic scan.
// RULE6 - scan mode zero is manual, one is automatic, two and three are reserved.
// RULE7 - in manual mode the four-bit channel id names the channel for the next conversion.
// RULE8 - the host must not pick a digital-use channel for a manual conversion.
// RULE9 - reserved bits of scan control and channel pick read zero and ignore writes.
// RULE10 - reset clears every register of the bank to zero.
// RULE11 - automatic scanning includes channel n only when bit n of the scan mask is set.
// RULE12 - a clear function bit makes a channel analog, a set one makes it a digital pin.
// RULE13 - a clear direction bit makes a digital pin an input, a set one an output.
// RULE14 - channel ids zero to seven pick channels zero to seven, eight and above are reserved.
// RULE15 - drive style and output level act only on pins set up as digital outputs.
package scan_regs_pkg;
    localparam int NUM_CH = 8;
    localparam logic [7:0] OFS_PIN_FUNC = 8'h05;
    localparam logic [7:0] OFS_PIN_DIR = 8'h07;
    localparam logic [7:0] OFS_OUTPUT_DRIVE_TYPE = 8'h09;
    localparam logic [7:0] OFS_OUTPUT_LEVEL_SET = 8'h0b;
    localparam logic [7:0] OFS_INPUT_LEVEL_READBACK = 8'h0d;
    localparam logic [7:0] OFS_SCAN_CONTROL = 8'h10;
    localparam logic [7:0] OFS_MANUAL_CHANNEL_PICK = 8'h11;
    localparam logic [7:0] OFS_SCAN_CHANNEL_MASK = 8'h12;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] SCAN_CTL_WMASK = 8'h13;
    localparam logic [7:0] CHAN_PICK_WMASK = 8'h0f;
    localparam int SCAN_RUN_BIT = 4;
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 1;
    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_AUTO = 2'h1;
    localparam logic [3:0] CH_ID_LIMIT = 4'h8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // arbitrary default bus address
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;
endpackage

// file: core/i2c_reg_port.sv
// i2c target that turns bus transfers into register writes and reads
// assumes scl and sda are already synchronous to the clock
module i2c_reg_port #(
    parameter logic [6:0] DEV_ADDR = scan_regs_pkg::DEV_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    // register side
    input wire logic [7:0] i_rd_data,
    output logic [7:0] o_ptr,
    output logic [7:0] o_wdata,
    output logic o_wr
);
    import scan_regs_pkg::*;

    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_REG, PH_WR, PH_RD} phase_t;
    typedef struct packed {
        phase_t phase;
        logic [3:0] cnt;
        logic in_ack;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic oe;
        logic wr;
        logic scl_d;
        logic sda_d;
    } port_t;

    port_t s;
    port_t next_s;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;

    assign rise = i_scl & ~s.scl_d;
    assign fall = ~i_scl & s.scl_d;
    assign start_c = i_scl & s.scl_d & s.sda_d & ~i_sda;
    assign stop_c = i_scl & s.scl_d & ~s.sda_d & i_sda;

    always_comb begin
        next_s = s;
        next_s.scl_d = i_scl;
        next_s.sda_d = i_sda;
        next_s.wr = 1'b0;
        if (start_c) begin
            next_s.phase = PH_ADDR;
            next_s.cnt = 4'h0;
            next_s.in_ack = 1'b0;
            next_s.oe = 1'b0;
        end else if (stop_c) begin
            next_s.phase = PH_IDLE;
            next_s.in_ack = 1'b0;
            next_s.oe = 1'b0;
        end else begin
            case (s.phase)
                PH_ADDR, PH_REG, PH_WR: begin
                    if (rise && !s.in_ack && s.cnt < BITS_PER_BYTE) begin
                        next_s.sh = {s.sh[6:0], i_sda};
                        next_s.cnt = s.cnt + 4'h1;
                    end else if (fall && !s.in_ack && s.cnt == BITS_PER_BYTE) begin
                        if (s.phase == PH_ADDR && s.sh[7:1] != DEV_ADDR) begin
                            next_s.phase = PH_IDLE;
                        end else begin
                            next_s.oe = 1'b1;
                            next_s.in_ack = 1'b1;
                            next_s.wr = (s.phase == PH_WR);
                        end
                    end else if (fall && s.in_ack) begin
                        next_s.oe = 1'b0;
                        next_s.in_ack = 1'b0;
                        next_s.cnt = 4'h0;
                        if (s.phase == PH_ADDR) begin
                            if (s.sh[0]) begin
                                next_s.phase = PH_RD;
                                next_s.tx = i_rd_data;
                                next_s.oe = ~i_rd_data[7];
                            end else begin
                                next_s.phase = PH_REG;
                            end
                        end else if (s.phase == PH_REG) begin
                            next_s.ptr = s.sh;
                            next_s.phase = PH_WR;
                        end else begin
                            next_s.ptr = s.ptr + 8'h01;
                        end
                    end
                end
                PH_RD: begin
                    if (rise && !s.in_ack && s.cnt < BITS_PER_BYTE) begin
                        next_s.cnt = s.cnt + 4'h1;
                    end else if (fall && !s.in_ack) begin
                        if (s.cnt == BITS_PER_BYTE) begin
                            next_s.oe = 1'b0;
                            next_s.in_ack = 1'b1;
                        end else begin
                            next_s.tx = {s.tx[6:0], 1'b0};
                            next_s.oe = ~s.tx[6];
                        end
                    end else if (rise && s.in_ack) begin
                        if (i_sda) begin
                            next_s.phase = PH_IDLE;
                        end else begin
                            next_s.ptr = s.ptr + 8'h01;
                        end
                    end else if (fall && s.in_ack) begin
                        next_s.in_ack = 1'b0;
                        next_s.cnt = 4'h0;
                        next_s.tx = i_rd_data;
                        next_s.oe = ~i_rd_data[7];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '{phase: PH_IDLE, default: '0};
            s.scl_d <= 1'b1;
            s.sda_d <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign o_sda_oe = s.oe;
    assign o_ptr = s.ptr;
    assign o_wdata = s.sh;
    assign o_wr = s.wr;
endmodule // i2c_reg_port

// file: core/gpio_and_scan_sequencer_regs.sv
// register bank for gpio drive, input readback and channel scan sequencing
// assumes synchronous pin samples and a converter that pulses i_conv_done
module gpio_and_scan_sequencer_regs #(
    parameter logic [6:0] DEV_ADDR = scan_regs_pkg::DEV_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // i2c pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // channel pins
    input wire logic [scan_regs_pkg::NUM_CH-1:0] i_ch_in,
    output logic [scan_regs_pkg::NUM_CH-1:0] o_ch_out,
    output logic [scan_regs_pkg::NUM_CH-1:0] o_ch_oe,
    // converter side
    input wire logic i_conv_done,
    output logic [3:0] o_conv_channel,
    output logic o_conv_valid,
    output logic o_scan_active
);
    import scan_regs_pkg::*;

    typedef struct packed {
        logic [7:0] pin_func;
        logic [7:0] pin_dir;
        logic [7:0] output_drive_type;
        logic [7:0] output_level_set;
        logic [7:0] input_level_readback;
        logic [7:0] scan_control;
        logic [7:0] manual_channel_pick;
        logic [7:0] scan_channel_mask;
        logic scanning;
        logic [3:0] conv_ch;
        logic conv_valid;
        logic [7:0] ch_out;
        logic [7:0] ch_oe;
    } bank_t;

    bank_t r;
    bank_t next_r;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] rd_data;
    logic [7:0] scan_en;
    logic [7:0] dig_out;
    logic [1:0] mode;
    logic [3:0] man_id;

    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (v[i]) idx = 3'(i);
        end
        return idx;
    endfunction

    function automatic logic [2:0] next_set(input logic [7:0] v, input logic [2:0] cur);
        logic [2:0] idx;
        logic hit;
        idx = first_set(v);
        hit = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (!hit && v[i] && 3'(i) > cur) begin
                idx = 3'(i);
                hit = 1'b1;
            end
        end
        return idx;
    endfunction

    i2c_reg_port #(
        .DEV_ADDR(DEV_ADDR)
    ) u_port (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda_oe(o_sda_oe),
        .i_rd_data(rd_data),
        .o_ptr(ptr),
        .o_wdata(wdata),
        .o_wr(wr)
    );

    assign o_sda_out = 1'b0;
    assign scan_en = r.scan_channel_mask & ~r.pin_func; // see RULE11
    assign dig_out = r.pin_func & r.pin_dir; // see RULE12 see RULE13
    assign mode = r.scan_control[MODE_MSB:MODE_LSB];
    assign man_id = r.manual_channel_pick[3:0];

    always_comb begin
        if (ptr == OFS_PIN_FUNC) begin
            rd_data = r.pin_func;
        end else if (ptr == OFS_PIN_DIR) begin
            rd_data = r.pin_dir;
        end else if (ptr == OFS_OUTPUT_DRIVE_TYPE) begin
            rd_data = r.output_drive_type;
        end else if (ptr == OFS_OUTPUT_LEVEL_SET) begin
            rd_data = r.output_level_set;
        end else if (ptr == OFS_INPUT_LEVEL_READBACK) begin
            rd_data = r.input_level_readback; // see RULE3
        end else if (ptr == OFS_SCAN_CONTROL) begin
            rd_data = r.scan_control;
        end else if (ptr == OFS_MANUAL_CHANNEL_PICK) begin
            rd_data = r.manual_channel_pick;
        end else if (ptr == OFS_SCAN_CHANNEL_MASK) begin
            rd_data = r.scan_channel_mask;
        end else begin
            rd_data = 8'h00;
        end
    end

    always_comb begin
        next_r = r;
        if (wr) begin
            if (ptr == OFS_PIN_FUNC) begin
                next_r.pin_func = wdata;
            end else if (ptr == OFS_PIN_DIR) begin
                next_r.pin_dir = wdata;
            end else if (ptr == OFS_OUTPUT_DRIVE_TYPE) begin
                next_r.output_drive_type = wdata;
            end else if (ptr == OFS_OUTPUT_LEVEL_SET) begin
                next_r.output_level_set = wdata;
            end else if (ptr == OFS_SCAN_CONTROL) begin
                next_r.scan_control = wdata & SCAN_CTL_WMASK; // see RULE9
            end else if (ptr == OFS_MANUAL_CHANNEL_PICK) begin
                next_r.manual_channel_pick = wdata & CHAN_PICK_WMASK; // see RULE9
            end else if (ptr == OFS_SCAN_CHANNEL_MASK) begin
                next_r.scan_channel_mask = wdata;
            end
        end
        // digital inputs only; other channels read low
        next_r.input_level_readback = i_ch_in & r.pin_func & ~r.pin_dir; // see RULE3
        for (int n = 0; n < NUM_CH; n++) begin
            if (!dig_out[n]) begin
                next_r.ch_oe[n] = 1'b0; // see RULE15
                next_r.ch_out[n] = 1'b0;
            end else if (r.output_drive_type[n]) begin
                next_r.ch_oe[n] = 1'b1; // see RULE1
                next_r.ch_out[n] = r.output_level_set[n]; // see RULE2
            end else begin
                next_r.ch_oe[n] = ~r.output_level_set[n]; // see RULE1 see RULE2
                next_r.ch_out[n] = 1'b0;
            end
        end
        case (mode) // see RULE6
            MODE_MANUAL: begin
                next_r.scanning = 1'b0;
                next_r.conv_ch = man_id; // see RULE7
                next_r.conv_valid = (man_id < CH_ID_LIMIT) && !r.pin_func[man_id[2:0]]; // see RULE14
            end
            MODE_AUTO: begin
                if (!r.scan_control[SCAN_RUN_BIT]) begin
                    next_r.scanning = 1'b0; // see RULE5
                    next_r.conv_valid = 1'b0;
                end else if (!r.scanning) begin
                    next_r.scanning = 1'b1;
                    next_r.conv_ch = {1'b0, first_set(scan_en)}; // see RULE4
                    next_r.conv_valid = |scan_en;
                end else if (i_conv_done) begin
                    next_r.conv_ch = {1'b0, next_set(scan_en, r.conv_ch[2:0])}; // see RULE4
                    next_r.conv_valid = |scan_en;
                end
            end
            default: begin
                next_r.scanning = 1'b0;
                next_r.conv_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0; // see RULE10
        end else begin
            r <= next_r;
        end
    end

    assign o_ch_out = r.ch_out;
    assign o_ch_oe = r.ch_oe;
    assign o_conv_channel = r.conv_ch;
    assign o_conv_valid = r.conv_valid;
    assign o_scan_active = r.scanning;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    a_pushpull_drive: assert property ( // see RULE1
        1 |=> ((o_ch_oe & $past(dig_out) & $past(r.output_drive_type))
            == ($past(dig_out) & $past(r.output_drive_type))))
        else $error("push-pull output not enabled");
    a_level_drive: assert property ( // see RULE2
        1 |=> ((o_ch_out & $past(dig_out) & $past(r.output_drive_type))
            == ($past(dig_out) & $past(r.output_drive_type) & $past(r.output_level_set))))
        else $error("push-pull level wrong");
    a_non_output_idle: assert property ( // see RULE15
        1 |=> ((o_ch_oe & ~$past(dig_out)) == 8'h00))
        else $error("non-output pin driven");
    a_input_sample: assert property ( // see RULE3
        1 |=> (r.input_level_readback
            == ($past(i_ch_in) & $past(r.pin_func) & ~$past(r.pin_dir))))
        else $error("input readback wrong");
    a_reserved_zero: assert property ( // see RULE9
        r.scan_control[7:5] == 3'h0 && r.scan_control[3:2] == 2'h0
            && r.manual_channel_pick[7:4] == 4'h0)
        else $error("reserved bits set");
    a_stop_on_clear: assert property ( // see RULE5
        (wr && ptr == OFS_SCAN_CONTROL && !wdata[SCAN_RUN_BIT]) |-> ##2 !o_scan_active)
        else $error("scan did not stop");
    a_scan_start_low: assert property ( // see RULE4
        $rose(o_scan_active) |-> o_conv_channel == {1'b0, first_set($past(scan_en))})
        else $error("scan did not start at lowest channel");
    a_manual_pick: assert property ( // see RULE7
        (mode == MODE_MANUAL && $stable(r.manual_channel_pick)) |=>
            (o_conv_channel == $past(man_id) && !o_scan_active))
        else $error("manual channel not followed");
    a_reserved_id: assert property ( // see RULE14
        (mode == MODE_MANUAL && man_id >= CH_ID_LIMIT) |=> !o_conv_valid)
        else $error("reserved channel id marked valid");
    a_reserved_mode: assert property ( // see RULE6
        mode[1] |=> (!o_scan_active && !o_conv_valid))
        else $error("reserved scan mode not idle");
endmodule // gpio_and_scan_sequencer_regs

// file: sim/i2c_host_model.sv
// i2c host model: register writes, and reads with a repeated start
// assumes the bench resolves sda with a pull-up and feeds it back
module i2c_host_model #(
    parameter logic [6:0] ADDR = 7'h00
) (
    // clock and bus
    input wire logic i_sys_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe,
    // read results
    output logic o_rd_valid,
    output logic [7:0] o_rd_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ack_ok;
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_byte = 8'h00;
        ack_ok = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    // one scl period: data set mid-low, sampled mid-high
    task automatic bit_cyc(input logic low, output logic seen);
        wait_clk(2);
        o_sda_oe <= low;
        wait_clk(2);
        o_scl <= 1'b1;
        wait_clk(2);
        seen = i_sda;
        wait_clk(2);
        o_scl <= 1'b0;
    endtask
    task automatic start_cond();
        wait_clk(2);
        o_sda_oe <= 1'b0;
        wait_clk(2);
        o_scl <= 1'b1;
        wait_clk(4);
        o_sda_oe <= 1'b1;
        wait_clk(4);
        o_scl <= 1'b0;
    endtask
    task automatic stop_cond();
        wait_clk(2);
        o_sda_oe <= 1'b1;
        wait_clk(2);
        o_scl <= 1'b1;
        wait_clk(4);
        o_sda_oe <= 1'b0;
        wait_clk(4);
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] wb, input logic ack_low, input logic chk,
                        output logic [7:0] rb);
        logic a;
        for (int i = 7; i >= 0; i--) bit_cyc(~wb[i], rb[i]);
        bit_cyc(ack_low, a);
        if (chk && a) ack_ok = 1'b0;
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic [7:0] r;
        start_cond();
        xfer({ADDR, 1'b0}, 1'b0, 1'b1, r);
        xfer(ofs, 1'b0, 1'b1, r);
        xfer(d, 1'b0, 1'b1, r);
        stop_cond();
    endtask
    task automatic rd(input logic [7:0] ofs);
        logic [7:0] r;
        start_cond();
        xfer({ADDR, 1'b0}, 1'b0, 1'b1, r);
        xfer(ofs, 1'b0, 1'b1, r);
        start_cond();
        xfer({ADDR, 1'b1}, 1'b0, 1'b1, r);
        xfer(8'hff, 1'b0, 1'b0, r);
        o_rd_byte <= r;
        o_rd_valid <= 1'b1;
        wait_clk(1);
        o_rd_valid <= 1'b0;
        stop_cond();
    endtask
endmodule // i2c_host_model

// file: sim/gpio_and_scan_sequencer_regs_bench.sv
// bench for the gpio and scan sequencer register bank
// assumes the i2c host model beside it and a pull-up on sda
module gpio_and_scan_sequencer_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import scan_regs_pkg::*;
    logic clk;
    logic rst_n;
    logic scl;
    logic sda;
    logic h_oe;
    logic sda_oe;
    logic sda_out;
    logic rd_valid;
    logic [7:0] rd_byte;
    logic [7:0] ch_in;
    logic [7:0] ch_out;
    logic [7:0] ch_oe;
    logic conv_done;
    logic [3:0] conv_channel;
    logic conv_valid;
    logic scan_active;
    int n_errors = 0;
    int total_checks = 0;
    logic [7:0] exp_q[$];
    logic [7:0] regs[6] = '{OFS_OUTPUT_DRIVE_TYPE, OFS_OUTPUT_LEVEL_SET,
        OFS_INPUT_LEVEL_READBACK, OFS_SCAN_CONTROL, OFS_MANUAL_CHANNEL_PICK,
        OFS_SCAN_CHANNEL_MASK};
    logic [3:0] ids[4] = '{4'h0, 4'h3, 4'h8, 4'hf};
    logic [3:0] adv[3] = '{4'h3, 4'h1, 4'h3};
    // open drain: the device may only ever pull the line low
    assign sda = !h_oe && (!sda_oe || sda_out);
    gpio_and_scan_sequencer_regs uut (
        .i_sys_clk(clk),
        .i_rst_n(rst_n),
        .i_scl(scl),
        .i_sda(sda),
        .o_sda_out(sda_out),
        .o_sda_oe(sda_oe),
        .i_ch_in(ch_in),
        .o_ch_out(ch_out),
        .o_ch_oe(ch_oe),
        .i_conv_done(conv_done),
        .o_conv_channel(conv_channel),
        .o_conv_valid(conv_valid),
        .o_scan_active(scan_active)
    );
    i2c_host_model #(.ADDR(DEV_ADDR_DEFAULT)) host (
        .i_sys_clk(clk),
        .i_sda(sda),
        .o_scl(scl),
        .o_sda_oe(h_oe),
        .o_rd_valid(rd_valid),
        .o_rd_byte(rd_byte)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rd_exp(input logic [7:0] ofs, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(ofs);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    // expected pins: push-pull drives the level, open drain pulls low only
    function automatic logic [15:0] pins(input logic [7:0] f, dr, ty, lv);
        return {f & dr & ty & lv, f & dr & (ty | ~lv)};
    endfunction
    // read results are compared in arrival order
    always @(posedge clk) begin
        if (rd_valid) begin
            if (exp_q.size() == 0) check(16'h1, 16'h0, "unexpected read");
            else check({8'h00, rd_byte}, {8'h00, exp_q.pop_front()}, "read data");
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] v, f, dr, ty, lv;
        rst_n = 1'b0;
        conv_done = 1'b0;
        ch_in = 8'h00;
        v = $urandom(32'hd0fd);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        check({ch_out, ch_oe}, 16'h0000, "pins after reset");
        check({scan_active, conv_channel}, 16'h0000, "scan after reset");
        foreach (regs[i]) rd_exp(regs[i], 8'h00);
        ch_in <= $urandom();
        for (int i = 0; i < 6; i++) begin
            v = $urandom();
            host.wr(regs[i], v);
            rd_exp(regs[i], (i == 2) ? 8'h00 : (i == 3) ? (v & SCAN_CTL_WMASK) :
                (i == 4) ? (v & CHAN_PICK_WMASK) : v);
        end
        host.wr(OFS_SCAN_CONTROL, 8'hec);
        rd_exp(OFS_SCAN_CONTROL, 8'h00);
        host.wr(OFS_MANUAL_CHANNEL_PICK, 8'hf0);
        rd_exp(OFS_MANUAL_CHANNEL_PICK, 8'h00);
        rd_exp(8'h20, 8'h00);
        for (int k = 0; k < 3; k++) begin
            f = $urandom();
            dr = $urandom();
            ty = $urandom();
            lv = $urandom();
            ch_in <= $urandom();
            host.wr(OFS_PIN_FUNC, f);
            host.wr(OFS_PIN_DIR, dr);
            host.wr(OFS_OUTPUT_DRIVE_TYPE, ty);
            host.wr(OFS_OUTPUT_LEVEL_SET, lv);
            settle();
            check({ch_out, ch_oe}, pins(f, dr, ty, lv), "pins");
            rd_exp(OFS_INPUT_LEVEL_READBACK, ch_in & f & ~dr);
        end
        host.wr(OFS_PIN_FUNC, 8'hf0);
        host.wr(OFS_SCAN_CONTROL, 8'h00);
        // only analog ids 0..3 or reserved ids are picked here
        foreach (ids[i]) begin
            host.wr(OFS_MANUAL_CHANNEL_PICK, {4'h0, ids[i]});
            settle();
            check({conv_valid, conv_channel}, {ids[i] < 4'h8, ids[i]}, "manual");
        end
        host.wr(OFS_MANUAL_CHANNEL_PICK, 8'h02);
        host.wr(OFS_SCAN_CHANNEL_MASK, 8'haa);
        for (int r = 0; r < 2; r++) begin
            host.wr(OFS_SCAN_CONTROL, 8'h11);
            settle();
            check({scan_active, conv_channel}, 16'h0011, "scan start");
            foreach (adv[i]) begin
                @(posedge clk);
                conv_done <= 1'b1;
                @(posedge clk);
                conv_done <= 1'b0;
                settle();
                check({12'h000, conv_channel}, {12'h000, adv[i]}, "scan step");
            end
            host.wr(OFS_SCAN_CONTROL, 8'h01);
            settle();
            check({15'h0000, scan_active}, 16'h0000, "scan stop");
        end
        for (int md = 0; md < 4; md++) begin
            host.wr(OFS_SCAN_CONTROL, 8'h10 | 8'(md));
            settle();
            check({scan_active, conv_valid}, {md == 1, md < 2}, "mode");
        end
        host.wr(OFS_SCAN_CHANNEL_MASK, 8'hf0);
        host.wr(OFS_SCAN_CONTROL, 8'h11);
        settle();
        check({15'h0000, conv_valid}, 16'h0000, "empty scan set");
        // reset in mid-run with outputs and registers away from zero
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        check({ch_out, ch_oe}, 16'h0000, "pins after second reset");
        check({scan_active, conv_channel}, 16'h0000, "scan after second reset");
        check({15'h0000, sda_out}, 16'h0000, "sda drive value");
        foreach (regs[i]) rd_exp(regs[i], 8'h00);
        rd_exp(OFS_PIN_FUNC, 8'h00);
        repeat (10) @(posedge clk);
        check(16'(exp_q.size()), 16'h0000, "reads outstanding");
        check({15'h0000, host.ack_ok}, 16'h0001, "acknowledges");
        tally_and_finish();
    end
endmodule // gpio_and_scan_sequencer_regs_bench
